// >>> hw/ppe_pkg.sv
// constants, state enum and shared decode for the parallel port engine
// assumes a single 100 MHz system clock and an 8-position host port window
package ppe_pkg;

    // ----------------------------------------------------------------
    // host port offsets
    // ----------------------------------------------------------------
    localparam logic [2:0] PPE_OFF_SPP_DATA = 3'h0;
    localparam logic [2:0] PPE_OFF_STATUS = 3'h1;
    localparam logic [2:0] PPE_OFF_CONTROL = 3'h2;
    localparam logic [2:0] PPE_OFF_LINK_ADDR = 3'h3;
    localparam logic [2:0] PPE_OFF_LINK_DATA0 = 3'h4;
    localparam logic [2:0] PPE_OFF_LINK_DATA1 = 3'h5;
    localparam logic [2:0] PPE_OFF_LINK_DATA2 = 3'h6;
    localparam logic [2:0] PPE_OFF_LINK_DATA3 = 3'h7;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int PPE_CTL_STROBE = 0;
    localparam int PPE_CTL_AUTOFD = 1;
    localparam int PPE_CTL_INIT = 2;
    localparam int PPE_CTL_SLCTIN = 3;
    localparam int PPE_CTL_IRQ_EN = 4;
    localparam int PPE_CTL_DIR = 5;
    localparam int PPE_CTL_W = 6;
    localparam int PPE_STS_TIMEOUT = 0;
    localparam int PPE_STS_ACK = 6;
    localparam int PPE_STS_BUSY = 7;
    localparam logic [5:0] PPE_CTL_RESET = 6'h00;
    localparam logic [7:0] PPE_BYTE_RESET = 8'h00;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int PPE_CLK_HZ = 100_000_000;
    localparam int PPE_TIMEOUT_NS = 10_000;
    // reached-limit check (>=): round down to whole cycles
    localparam int PPE_TIMEOUT_CYC = (PPE_TIMEOUT_NS * (PPE_CLK_HZ / 1_000_000)) / 1000;
    localparam int PPE_TMO_W = 12;

    // ----------------------------------------------------------------
    // write queue shape
    // ----------------------------------------------------------------
    localparam int PPE_FIFO_W = 9;
    localparam int PPE_FIFO_D = 8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_LOW,
        ST_SETUP,
        ST_STROBE,
        ST_TERM,
        ST_HOSTEND
    } ppe_state_e;

    // offsets 3..7 run link cycles
    function automatic logic ppe_is_link_port(input logic [2:0] addr);
        ppe_is_link_port = (addr >= PPE_OFF_LINK_ADDR);
    endfunction : ppe_is_link_port

endpackage : ppe_pkg

// >>> hw/ppe_fifo.sv
// small write queue with a registered output stage
// assumes one clock; ce freezes all state
module ppe_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    // ----------------------------------------------------------------
    // handshakes
    // ----------------------------------------------------------------
    // pop moves the oldest stored word into the output register
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign push = in_valid & in_ready;
    assign pop = (cnt_r != '0) & (~out_valid | out_ready);

    // storage array, no reset needed on data
    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else if (ce) begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // output register; read data always comes from a flop
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (ce) begin
            if (pop) begin
                out_valid <= 1'b1;
                out_data <= mem_r[rd_ptr_r];
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end

endmodule : ppe_fifo

// >>> hw/ppe_engine.sv
// enhanced parallel port engine: host port registers and interlocked link cycles
// assumes host strobes, address and cable inputs are synchronous to clk
//
// What this block does
// - ack rising edge raises irq when enabled
// - direction bit only counts in extended mode
// - control bits 6 and 7 read zero
// - offset 3 write runs address write cycle
// - offset 3 read captures lines at strobe end
// - offset 4 runs data cycles, enhanced mode only
// - offsets 5-7 behave as data port 0
// - idle lines follow control port and direction
// - newer variant aborts after 10us without wait
// - older variant aborts after 10us host strobe
// - control strobe bit forces write during cycle
// - write with direction set becomes silent read
// - newer variant holds ready low until done
// - newer write: wait low, drive, then strobe
// - wait high ends strobe; change after wait low
// - newer read: release lines, strobe, capture on wait
// - older variant stretches host while wait low
// - older strobe follows host strobe, latch at end
// - timeout flag clears by writing one
// - direction output high only for input or reads
module ppe_engine (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic epp_mode_en,
    input wire logic epp_v19_sel,
    input wire logic extended_mode_cfg_bit,
    input wire logic [2:0] host_addr,
    input wire logic [7:0] system_data_bus_in,
    output logic [7:0] system_data_bus_out,
    output logic system_data_bus_oe,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    output logic iochrdy_out,
    output logic iochrdy_oe,
    input wire logic [7:0] parallel_data_lines_in,
    output logic [7:0] parallel_data_lines_out,
    output logic parallel_data_lines_oe,
    input wire logic wait_n_in,
    input wire logic ack_n_in,
    output logic write_strobe_n_out,
    output logic data_strobe_n_out,
    output logic init_n_out,
    output logic addr_strobe_n_out,
    output logic direction_indicator_out,
    output logic irq_out
);
    import ppe_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic rd_n_d_r, wr_n_d_r, ack_d_r;
    logic [7:0] host_byte_r;
    logic [PPE_CTL_W-1:0] ctrl_r;
    logic [7:0] spp_data_r, link_addr_r, link_data_r, rd_capture_r;
    logic timeout_r, wr_pend_r, rd_pend_r;
    logic [PPE_FIFO_W-1:0] wr_pend_word_r;
    ppe_state_e state_r, state_nxt;
    logic v19_r, cyc_req_write_r, cyc_addr_r;
    logic [7:0] cyc_byte_r;
    logic [PPE_TMO_W-1:0] tmo_cnt_r;
    logic rd_lead, wr_lead, wr_trail, host_strobe_low, link_ok, pcd_eff, bus_write, rd_take;
    logic tmo_hit, tmo_armed, start_cyc, start_write, abort, term_19, end_17;
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [PPE_FIFO_W-1:0] fifo_out_data;

    // ----------------------------------------------------------------
    // host strobe edges and decode
    // ----------------------------------------------------------------
    assign rd_lead = rd_n_d_r & ~host_rd_n;
    assign wr_lead = wr_n_d_r & ~host_wr_n;
    assign wr_trail = ~wr_n_d_r & host_wr_n;
    assign host_strobe_low = ~host_rd_n | ~host_wr_n;
    // link ports answer only in enhanced mode
    assign link_ok = epp_mode_en & ppe_is_link_port(host_addr);
    // direction bit is ignored in printer mode
    assign pcd_eff = ctrl_r[PPE_CTL_DIR] & ~extended_mode_cfg_bit;
    // strobe bit wins; a write with direction set degrades to a read
    assign bus_write = ctrl_r[PPE_CTL_STROBE] | (cyc_req_write_r & ~pcd_eff);
    // read sample edge; the host bus takes the same byte so ready never leads the data
    assign rd_take = ~bus_write & (term_19 | (~v19_r & (state_r == ST_STROBE) & wait_n_in));

    // previous strobe levels and host byte sampled while iow is low
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_n_d_r <= 1'b1;
            wr_n_d_r <= 1'b1;
            ack_d_r <= 1'b1;
            host_byte_r <= PPE_BYTE_RESET;
        end else if (ce) begin
            rd_n_d_r <= host_rd_n;
            wr_n_d_r <= host_wr_n;
            ack_d_r <= ack_n_in;
            if (!host_wr_n) begin
                host_byte_r <= system_data_bus_in;
            end
        end
    end

    // ----------------------------------------------------------------
    // control, data and status registers
    // ----------------------------------------------------------------
    // plain registers latch on the trailing edge of iow
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= PPE_CTL_RESET;
            spp_data_r <= PPE_BYTE_RESET;
        end else if (ce && wr_trail) begin
            if (host_addr == PPE_OFF_CONTROL) begin
                ctrl_r <= host_byte_r[PPE_CTL_W-1:0];
            end
            if (host_addr == PPE_OFF_SPP_DATA) begin
                spp_data_r <= host_byte_r;
            end
        end
    end

    // timeout flag: abort sets, writing one clears, set wins
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            timeout_r <= 1'b0;
        end else if (ce) begin
            if (abort) begin
                timeout_r <= 1'b1;
            end else if (wr_trail && host_addr == PPE_OFF_STATUS && host_byte_r[PPE_STS_TIMEOUT]) begin
                timeout_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // write queue feeding the link engine
    // ----------------------------------------------------------------
    // a full queue keeps the request pending; only the newer variant also holds iochrdy low
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend_r <= 1'b0;
            wr_pend_word_r <= '0;
        end else if (ce) begin
            if (wr_lead && link_ok) begin
                wr_pend_r <= 1'b1;
                wr_pend_word_r <= {host_addr == PPE_OFF_LINK_ADDR, system_data_bus_in};
            end else if (fifo_in_ready) begin
                wr_pend_r <= 1'b0;
            end
        end
    end

    ppe_fifo #(
        .WIDTH(PPE_FIFO_W),
        .DEPTH(PPE_FIFO_D)
    ) u_wr_queue (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .in_valid(wr_pend_r),
        .in_ready(fifo_in_ready),
        .in_data(wr_pend_word_r),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // read request waits for the engine to go idle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_pend_r <= 1'b0;
        end else if (ce) begin
            if (rd_lead && link_ok) begin
                rd_pend_r <= 1'b1;
            end else if (start_cyc && !start_write) begin
                rd_pend_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // link cycle sequencer
    // ----------------------------------------------------------------
    assign start_write = fifo_out_valid;
    assign start_cyc = (state_r == ST_IDLE) & (fifo_out_valid | rd_pend_r);
    assign fifo_out_ready = (state_r == ST_IDLE);
    assign tmo_hit = (tmo_cnt_r >= PPE_TMO_W'(PPE_TIMEOUT_CYC));
    // newer variant times until wait rises, older until host strobe ends
    assign tmo_armed = v19_r ? (state_r == ST_WAIT_LOW || state_r == ST_SETUP || state_r == ST_STROBE)
                             : (state_r == ST_STROBE);
    assign abort = tmo_armed & tmo_hit;
    assign term_19 = v19_r & (state_r == ST_STROBE) & wait_n_in & ~tmo_hit;
    assign end_17 = ~v19_r & (state_r == ST_STROBE) & ~host_strobe_low & ~tmo_hit;

    // next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_cyc) begin
                    state_nxt = epp_v19_sel ? ST_WAIT_LOW : ST_SETUP;
                end
            end
            ST_WAIT_LOW: begin
                if (abort) begin
                    state_nxt = ST_HOSTEND;
                end else if (!wait_n_in) begin
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP: begin
                state_nxt = abort ? ST_HOSTEND : ST_STROBE;
            end
            ST_STROBE: begin
                if (abort) begin
                    state_nxt = ST_HOSTEND;
                end else if (term_19) begin
                    state_nxt = ST_TERM;
                end else if (end_17) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_TERM: begin
                if (!wait_n_in) begin
                    state_nxt = ST_HOSTEND;
                end
            end
            ST_HOSTEND: begin
                if (!host_strobe_low) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // state and cycle context, latched at cycle start
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            v19_r <= 1'b0;
            cyc_req_write_r <= 1'b0;
            cyc_addr_r <= 1'b0;
            cyc_byte_r <= PPE_BYTE_RESET;
        end else if (ce) begin
            state_r <= state_nxt;
            if (start_cyc) begin
                v19_r <= epp_v19_sel;
                cyc_req_write_r <= start_write;
                cyc_addr_r <= start_write ? fifo_out_data[8] : (host_addr == PPE_OFF_LINK_ADDR);
                cyc_byte_r <= fifo_out_data[7:0];
            end
        end
    end

    // watchdog counter restarts with every cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tmo_cnt_r <= '0;
        end else if (ce) begin
            if (start_cyc) begin
                tmo_cnt_r <= '0;
            end else if (tmo_armed && !tmo_hit) begin
                tmo_cnt_r <= tmo_cnt_r + 1'b1;
            end
        end
    end

    // link registers latch at termination; read data held for the host
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_addr_r <= PPE_BYTE_RESET;
            link_data_r <= PPE_BYTE_RESET;
            rd_capture_r <= PPE_BYTE_RESET;
        end else if (ce) begin
            if ((term_19 || end_17) && bus_write) begin
                if (cyc_addr_r) begin
                    link_addr_r <= host_byte_r;
                end else begin
                    link_data_r <= host_byte_r;
                end
            end
            if (rd_take) begin
                rd_capture_r <= parallel_data_lines_in;
            end
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    // cable side: idle lines follow the control port, cycles take over
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            write_strobe_n_out <= 1'b1;
            data_strobe_n_out <= 1'b1;
            addr_strobe_n_out <= 1'b1;
            init_n_out <= 1'b0;
            parallel_data_lines_out <= PPE_BYTE_RESET;
            parallel_data_lines_oe <= 1'b1;
            direction_indicator_out <= 1'b0;
        end else if (ce) begin
            init_n_out <= ctrl_r[PPE_CTL_INIT];
            if (state_nxt == ST_SETUP || state_nxt == ST_STROBE || state_nxt == ST_TERM) begin
                write_strobe_n_out <= ~bus_write;
                parallel_data_lines_oe <= bus_write;
                direction_indicator_out <= ~bus_write;
                // lines hold the cycle byte until the latched copy is valid
                parallel_data_lines_out <= (state_r == ST_TERM) ? (cyc_addr_r ? link_addr_r : link_data_r)
                                                                : cyc_byte_r;
                data_strobe_n_out <= ~(state_nxt == ST_STROBE && !cyc_addr_r);
                addr_strobe_n_out <= ~(state_nxt == ST_STROBE && cyc_addr_r);
            end else begin
                write_strobe_n_out <= ~ctrl_r[PPE_CTL_STROBE];
                data_strobe_n_out <= ~ctrl_r[PPE_CTL_AUTOFD];
                addr_strobe_n_out <= ~ctrl_r[PPE_CTL_SLCTIN];
                parallel_data_lines_out <= spp_data_r;
                parallel_data_lines_oe <= ~pcd_eff;
                direction_indicator_out <= pcd_eff;
            end
        end
    end

    // host side: ready stretch, read data and interrupt
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            iochrdy_out <= 1'b0;
            iochrdy_oe <= 1'b0;
            system_data_bus_out <= PPE_BYTE_RESET;
            system_data_bus_oe <= 1'b0;
            irq_out <= 1'b0;
        end else if (ce) begin
            iochrdy_out <= 1'b0;
            if (epp_v19_sel) begin
                // held from request until the handshake lets the host finish
                iochrdy_oe <= wr_pend_r | rd_pend_r | start_cyc | (state_nxt == ST_WAIT_LOW)
                              | (state_nxt == ST_SETUP) | (state_nxt == ST_STROBE)
                              | ((state_r == ST_IDLE) & link_ok & ~wr_n_d_r);
            end else begin
                iochrdy_oe <= (state_nxt == ST_STROBE) & ~wait_n_in;
            end
            system_data_bus_oe <= ~host_rd_n & (link_ok | ~ppe_is_link_port(host_addr));
            case (host_addr)
                PPE_OFF_SPP_DATA: system_data_bus_out <= parallel_data_lines_in;
                PPE_OFF_STATUS: system_data_bus_out <= {~wait_n_in, ack_n_in, 5'b0_0000, timeout_r};
                PPE_OFF_CONTROL: system_data_bus_out <= {2'b00, ctrl_r};
                default: system_data_bus_out <= rd_take ? parallel_data_lines_in : rd_capture_r;
            endcase
            irq_out <= ctrl_r[PPE_CTL_IRQ_EN] & ~ack_d_r & ack_n_in;
        end
    end

endmodule : ppe_engine

// >>> verif/ppe_sva.sv
// checker for the parallel port engine, watching its ports only
// assumes ppe_engine port names; the bind sits below the module
module ppe_sva (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic epp_mode_en,
    input wire logic epp_v19_sel,
    input wire logic [2:0] host_addr,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic iochrdy_oe,
    input wire logic parallel_data_lines_oe,
    input wire logic wait_n_in,
    input wire logic ack_n_in,
    input wire logic write_strobe_n_out,
    input wire logic data_strobe_n_out,
    input wire logic addr_strobe_n_out,
    input wire logic direction_indicator_out,
    input wire logic irq_out
);
    import ppe_pkg::*;
    int rdy_cnt_r;
    wire stb_n = data_strobe_n_out & addr_strobe_n_out;
    // length of the current host stretch, a stuck ready shows up here
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) rdy_cnt_r <= 0;
        else rdy_cnt_r <= iochrdy_oe ? rdy_cnt_r + 1 : 0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_irq_pulse: assert property (irq_out |-> $past(ack_n_in) ##1 !irq_out)
        else $error("irq without ack rise or too long");
    a_write_setup: assert property (iochrdy_oe && $fell(stb_n) && !write_strobe_n_out |-> parallel_data_lines_oe)
        else $error("write strobe without driven lines");
    a_read_release: assert property (iochrdy_oe && $fell(stb_n) && write_strobe_n_out
        |-> !parallel_data_lines_oe && direction_indicator_out)
        else $error("read strobe with lines driven");
    a_wait_first: assert property (iochrdy_oe && $fell(stb_n) |-> !$past(wait_n_in))
        else $error("strobe before wait low");
    a_ready_drop: assert property ($rose(wait_n_in) && iochrdy_oe |-> ##[1:3] !iochrdy_oe)
        else $error("ready held after wait high");
    a_ready_bound: assert property (rdy_cnt_r < PPE_TIMEOUT_CYC + 10)
        else $error("stretch outlived the watchdog");
    a_ready_rise: assert property ($fell(host_rd_n & host_wr_n) && epp_mode_en && epp_v19_sel
        && host_addr >= 3'h3 |-> ##[1:8] iochrdy_oe)
        else $error("link cycle without stretch");
    a_addr_strobe: assert property (iochrdy_oe && !addr_strobe_n_out |-> host_addr == 3'h3 && data_strobe_n_out)
        else $error("address strobe on wrong port");
endmodule : ppe_sva

bind ppe_engine ppe_sva u_ppe_sva (.*);

// >>> verif/ppe_periph.sv
// peripheral on the cable side of the engine
// assumes strobes change just after clk; answers after dly cycles
module ppe_periph (
    input wire logic clk,
    input wire logic stall,
    input wire logic [7:0] dly,
    input wire logic [7:0] rd_byte,
    input wire logic wr_n,
    input wire logic ds_n,
    input wire logic as_n,
    input wire logic pd_oe,
    input wire logic [7:0] pd_out,
    output logic [7:0] line,
    output logic wait_n,
    output logic [7:0] got,
    output logic last_wr_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv = 1'b0;
    logic [7:0] last = 8'h00;
    int n = 0;
    // released lines show the inverse of the last byte, never a stale copy
    assign line = pd_oe ? pd_out : (drv ? rd_byte : ~last);
    initial begin
        wait_n = 1'b0;
        got = 8'h00;
        last_wr_n = 1'b1;
    end
    // stall holds wait low forever so the watchdog can be exercised
    always @(posedge clk) begin
        #1;
        if (!ds_n || !as_n) begin
            drv = wr_n;
            last_wr_n = wr_n;
            if (!wr_n) got = line;
            n = n + 1;
            if (n > dly && !stall) wait_n = 1'b1;
        end else begin
            if (drv) last = rd_byte;
            drv = 1'b0;
            wait_n = 1'b0;
            n = 0;
        end
    end
endmodule : ppe_periph

// >>> verif/testbench.sv
// self-checking bench for the parallel port engine
// assumes ppe_engine, ppe_periph and the bound checker are compiled first
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %s exp %h got %h", nm, e, g); end end
    logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, epp_mode_en = 1'b1, epp_v19_sel = 1'b1;
    logic extended_mode_cfg_bit = 1'b0, host_rd_n = 1'b1, host_wr_n = 1'b1, ack_n_in = 1'b1, stall = 1'b0;
    logic [2:0] host_addr = 3'h0;
    logic [7:0] system_data_bus_in = 8'h00, dly = 8'h02, rd_byte = 8'h00, rdq;
    logic [7:0] system_data_bus_out, parallel_data_lines_out, line, got;
    logic system_data_bus_oe, iochrdy_oe, parallel_data_lines_oe, wait_n_in, write_strobe_n_out, rdoe, seen, iochrdy_out;
    logic data_strobe_n_out, init_n_out, addr_strobe_n_out, direction_indicator_out, irq_out, last_wr_n;
    int n_mismatch = 0;
    int n_tests = 0;
    ppe_engine u_ppe_engine (.clk, .sys_rst, .ce, .epp_mode_en, .epp_v19_sel, .extended_mode_cfg_bit, .host_addr,
        .system_data_bus_in, .system_data_bus_out, .system_data_bus_oe, .host_rd_n, .host_wr_n, .iochrdy_out,
        .iochrdy_oe, .parallel_data_lines_in(line), .parallel_data_lines_out, .parallel_data_lines_oe, .wait_n_in,
        .ack_n_in, .write_strobe_n_out, .data_strobe_n_out, .init_n_out, .addr_strobe_n_out,
        .direction_indicator_out, .irq_out);
    ppe_periph u_ppe_periph (.clk, .stall, .dly, .rd_byte, .wr_n(write_strobe_n_out), .ds_n(data_strobe_n_out),
        .as_n(addr_strobe_n_out), .pd_oe(parallel_data_lines_oe), .pd_out(parallel_data_lines_out), .line,
        .wait_n(wait_n_in), .got, .last_wr_n);
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    task automatic test_done;
        $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    // one host access; the strobe stays low until the stretch is released
    task automatic acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
        int i;
        host_addr = a;
        system_data_bus_in = d;
        host_wr_n = !wr;
        host_rd_n = wr;
        repeat (8) tick;
        for (i = 0; i < 1500 && iochrdy_oe !== 1'b0; i++) tick;
        if (i == 1500) begin
            n_mismatch++;
            test_done();
        end
        rdq = system_data_bus_out;
        rdoe = system_data_bus_oe;
        host_wr_n = 1'b1;
        host_rd_n = 1'b1;
        repeat (3) tick;
    endtask : acc
    task automatic ack_pulse(input logic e);
        seen = 1'b0;
        ack_n_in = 1'b0;
        repeat (3) tick;
        ack_n_in = 1'b1;
        repeat (6) begin
            tick;
            if (irq_out === 1'b1) seen = 1'b1;
        end
        `CHK("irq", e, seen)
    endtask : ack_pulse
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (2) tick;
        sys_rst = 1'b0;
        repeat (2) tick;
        acc(1'b0, 3'h2, 8'h00);
        `CHK("ctl reset", 8'h00, rdq)
        `CHK("ready level", 1'b0, iochrdy_out)
        acc(1'b1, 3'h2, 8'hFF);
        acc(1'b0, 3'h2, 8'h00);
        `CHK("ctl", 8'h3F, rdq)
        `CHK("idle pins", 4'b0010, {write_strobe_n_out, data_strobe_n_out, init_n_out, addr_strobe_n_out})
        `CHK("pd_oe in", 1'b0, parallel_data_lines_oe)
        `CHK("dir in", 1'b1, direction_indicator_out)
        extended_mode_cfg_bit = 1'b1;
        repeat (3) tick;
        `CHK("pd_oe printer", 1'b1, parallel_data_lines_oe)
        extended_mode_cfg_bit = 1'b0;
        ack_pulse(1'b1);
        acc(1'b1, 3'h2, 8'h04);
        ack_pulse(1'b0);
        for (int a = 3; a < 8; a++) begin
            acc(1'b1, a[2:0], 8'hA0 + a[7:0]);
            `CHK("link wr", 8'hA0 + a[7:0], got)
            rd_byte = 8'h5A ^ a[7:0];
            acc(1'b0, a[2:0], 8'h00);
            `CHK("link rd", rd_byte, rdq)
        end
        acc(1'b1, 3'h2, 8'h24);
        acc(1'b1, 3'h4, 8'h33);
        `CHK("dir write", 1'b1, last_wr_n)
        acc(1'b0, 3'h1, 8'h00);
        `CHK("no error", 1'b0, rdq[0])
        acc(1'b1, 3'h2, 8'h25);
        acc(1'b0, 3'h4, 8'h00);
        `CHK("forced write", 1'b0, last_wr_n)
        acc(1'b1, 3'h2, 8'h04);
        stall = 1'b1;
        acc(1'b1, 3'h4, 8'h11);
        stall = 1'b0;
        acc(1'b0, 3'h1, 8'h00);
        `CHK("timeout", 1'b1, rdq[0])
        acc(1'b1, 3'h1, 8'h00);
        acc(1'b0, 3'h1, 8'h00);
        `CHK("timeout w0", 1'b1, rdq[0])
        acc(1'b1, 3'h1, 8'h01);
        acc(1'b0, 3'h1, 8'h00);
        `CHK("timeout w1", 1'b0, rdq[0])
        epp_mode_en = 1'b0;
        acc(1'b0, 3'h4, 8'h00);
        `CHK("link off", 1'b0, rdoe)
        epp_mode_en = 1'b1;
        epp_v19_sel = 1'b0;
        dly = 8'd20;
        acc(1'b1, 3'h4, 8'h6C);
        `CHK("older wr", 8'h6C, got)
        stall = 1'b1;
        acc(1'b1, 3'h5, 8'h77);
        stall = 1'b0;
        acc(1'b0, 3'h1, 8'h00);
        `CHK("older timeout", 1'b1, rdq[0])
        acc(1'b1, 3'h2, 8'h24);
        rd_byte = 8'hC3;
        acc(1'b0, 3'h6, 8'h00);
        `CHK("older rd", 8'hC3, rdq)
        test_done();
    end
endmodule : testbench
